//--- hw/smpm_pkg.sv
// Package with mode codes, register layout and timing constants for the sleep-mode manager.
package smpm_pkg;
  localparam logic [2:0] MODE_IDLE   = 3'h0;
  localparam logic [2:0] MODE_RES1   = 3'h1;
  localparam logic [2:0] MODE_PDOWN  = 3'h2;
  localparam logic [2:0] MODE_PSAVE  = 3'h3;
  localparam logic [2:0] MODE_RES4   = 3'h4;
  localparam logic [2:0] MODE_RES5   = 3'h5;
  localparam logic [2:0] MODE_STBY   = 3'h6;
  localparam logic [2:0] MODE_XSTBY  = 3'h7;

  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_WAKE   = 4'h8;

  localparam int CTRL_SLEEP_EN_BIT = 0;
  localparam int CTRL_MODE_LSB     = 1;
  localparam int CTRL_JTAG_OFF_BIT = 4;
  localparam int CTRL_CMP_OFF_BIT  = 5;
  localparam int CTRL_ACBG_BIT     = 6;
  localparam int CTRL_T2_ASYNC_BIT = 7;

  localparam int PIN_A   = 1;
  localparam int PIN_B   = 2;
  localparam int PIN_C   = 3;
  localparam int PIN_CHG = 4;
  localparam int PIN_OVF = 5;
  localparam int PIN_CMP = 6;

  localparam int WAKE_HALT_CYCLES = 4;
  localparam int STBY_WAKE_CYCLES = 6;
  localparam int CNT_W            = 16;

  typedef enum logic [2:0] {
    SMPM_RUN,
    SMPM_SLEEP,
    SMPM_STARTUP,
    SMPM_HALT
  } smpm_state_t;
endpackage : smpm_pkg

//--- hw/smpm_top.sv
// Sleep-mode manager: mode decode, clock gating, wake-up sequencing and power-helper control.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module smpm_top #(
  parameter int STARTUP_CYCLES = 16   // Fuse-selected oscillator start-up, in clock cycles.
) (
  input  wire logic        clk_sys,          // System clock, 125 MHz.
  input  wire logic        resetn,           // Synchronous reset, active low.
  input  wire logic [3:0]  reg_addr,         // Register byte address.
  input  wire logic [7:0]  reg_wdata,        // Register write data.
  input  wire logic        reg_wr,           // Write strobe.
  input  wire logic        reg_rd,           // Read strobe.
  output logic      [7:0]  reg_rdata,        // Read data, cycle after strobe.
  input  wire logic        sleep_instr,      // One-cycle pulse: sleep instruction executed.
  input  wire logic        crystal_sel,      // Clock source fuses select crystal.
  input  wire logic        debug_enable_fuse, // On-chip debug fuse programmed.
  input  wire logic        jtag_enable_fuse, // JTAG fuse programmed.
  input  wire logic        bod_fuse_en,      // Brown-out enabled by level fuses.
  input  wire logic        wdt_en,           // Watchdog enabled.
  input  wire logic        tap_shifting,     // TAP controller shifting data.
  input  wire logic        tdo_data,         // Data to drive on TDO.
  input  wire logic        sys_reset_req,    // Any reset source active (same domain).
  input  wire logic        global_irq_en,    // Global interrupt enable flag.
  input  wire logic        irq_pending,      // Any enabled interrupt pending.
  input  wire logic        ext_irq_a,        // External interrupt a pin.
  input  wire logic        ext_irq_b,        // External interrupt b pin.
  input  wire logic        ext_irq_c,        // External interrupt c pin.
  input  wire logic        ext_a_level_en,   // Irq a enabled and level-sensitive.
  input  wire logic        ext_b_level_en,   // Irq b enabled and level-sensitive.
  input  wire logic        ext_c_en,         // Irq c enabled.
  input  wire logic        pin_change,       // Pin change pin event level.
  input  wire logic        pin_change_en,    // Pin change irq enabled.
  input  wire logic        t2_ovf,           // Timer 2 overflow event (async pin).
  input  wire logic        t2_cmp,           // Timer 2 compare event (async pin).
  input  wire logic        t2_ovf_ie,        // Timer 2 overflow irq enable.
  input  wire logic        t2_cmp_ie,        // Timer 2 compare irq enable.
  output logic             core_clock_en,    // Core clock domain enable.
  output logic             program_memory_clock_en, // Program memory clock enable.
  output logic             peripheral_clock_en, // Peripheral clock domain enable.
  output logic             async_timer_clock_en, // Async timer clock domain enable.
  output logic             main_osc_en,      // Main oscillator enable.
  output logic             timer_osc_en,     // Timer oscillator enable.
  output logic             comparator_en,    // Analog comparator powered.
  output logic             vref_en,          // Internal reference powered.
  output logic             bod_en,           // Brown-out detector powered.
  output logic             wdt_run,          // Watchdog running.
  output logic             input_buf_en,     // General digital input buffers enabled.
  output logic             wake_buf_en,      // Wake-source input buffers enabled.
  output logic             jtag_active,      // JTAG interface enabled.
  output logic             tdo_o,            // TDO output value.
  output logic             tdo_oe,           // TDO output enable.
  output logic             cpu_resume,       // Pulse: core resumes after sleep.
  output logic             cpu_reset_vector  // Pulse: core restarts at reset vector.
);
  // ---------------------------------------------------------------
  // Registers and synchronisers
  // ---------------------------------------------------------------
  logic [7:0]                ctrl;
  smpm_pkg::smpm_state_t     state;
  logic [2:0]                cur_mode;
  logic [smpm_pkg::CNT_W-1:0] cnt;
  logic [6:0]                s1;
  logic [6:0]                s2;
  logic [6:0]                s3;

  // Pins from outside the clock domain pass three flip-flops.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s1 <= 7'h00;
      s2 <= 7'h00;
      s3 <= 7'h00;
    end else begin
      s1 <= {t2_cmp, t2_ovf, pin_change, ext_irq_c, ext_irq_b, ext_irq_a, 1'b0};
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change counts only once the second and third stages agree.
  logic [6:0] pin_f;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pin_f <= 7'h00;
    end else begin
      pin_f <= (s2 == s3) ? s3 : pin_f;
    end
  end

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  function automatic logic mode_valid(input logic [2:0] m, input logic xtal);
    case (m)
      smpm_pkg::MODE_IDLE, smpm_pkg::MODE_PDOWN, smpm_pkg::MODE_PSAVE: mode_valid = 1'b1;
      smpm_pkg::MODE_STBY, smpm_pkg::MODE_XSTBY: mode_valid = xtal;
      default: mode_valid = 1'b0;
    endcase
  endfunction : mode_valid

  wire [2:0] sel_mode     = ctrl[smpm_pkg::CTRL_MODE_LSB +: 3];
  wire       sleep_bit    = ctrl[smpm_pkg::CTRL_SLEEP_EN_BIT];
  wire       jtag_off_bit = ctrl[smpm_pkg::CTRL_JTAG_OFF_BIT];
  wire       cmp_off_bit  = ctrl[smpm_pkg::CTRL_CMP_OFF_BIT];
  wire       ac_bg        = ctrl[smpm_pkg::CTRL_ACBG_BIT];
  wire       t2_async     = ctrl[smpm_pkg::CTRL_T2_ASYNC_BIT];
  wire       asleep    = (state == smpm_pkg::SMPM_SLEEP);
  wire       enter     = sleep_instr && sleep_bit && mode_valid(sel_mode, crystal_sel);
  wire       is_idle   = asleep && (cur_mode == smpm_pkg::MODE_IDLE);
  wire       is_deep   = asleep && !is_idle;
  wire       save_like = (cur_mode == smpm_pkg::MODE_PSAVE) || (cur_mode == smpm_pkg::MODE_XSTBY);
  wire       stby_like = (cur_mode == smpm_pkg::MODE_STBY) || (cur_mode == smpm_pkg::MODE_XSTBY);
  wire       pd_or_ps  = (cur_mode == smpm_pkg::MODE_PDOWN) || (cur_mode == smpm_pkg::MODE_PSAVE);
  wire       jtag_on   = jtag_enable_fuse && !jtag_off_bit;

  // ---------------------------------------------------------------
  // Wake sources
  // ---------------------------------------------------------------
  // Edge-triggered lower irqs cannot wake from deep sleep: only the level-enabled path counts.
  wire lvl_a     = pin_f[smpm_pkg::PIN_A] && ext_a_level_en;
  wire lvl_b     = pin_f[smpm_pkg::PIN_B] && ext_b_level_en;
  wire irq_c     = pin_f[smpm_pkg::PIN_C] && ext_c_en;
  wire chg_wake  = pin_f[smpm_pkg::PIN_CHG] && pin_change_en;
  wire deep_ext  = lvl_a || lvl_b || irq_c || chg_wake;
  wire t2_event  = (pin_f[smpm_pkg::PIN_OVF] && t2_ovf_ie) ||
                   (pin_f[smpm_pkg::PIN_CMP] && t2_cmp_ie);
  wire t2_wake   = save_like && t2_async && global_irq_en && t2_event;
  wire idle_wake = irq_pending;
  wire wake      = is_idle ? idle_wake : (deep_ext || t2_wake);

  // Idle keeps the oscillator up, so it spends a single cycle in start-up.
  wire [smpm_pkg::CNT_W-1:0] startup_len =
    stby_like ? smpm_pkg::CNT_W'(smpm_pkg::STBY_WAKE_CYCLES)
              : (is_idle ? smpm_pkg::CNT_W'(1) : smpm_pkg::CNT_W'(STARTUP_CYCLES));

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state            <= smpm_pkg::SMPM_RUN;
      cur_mode         <= smpm_pkg::MODE_IDLE;
      cnt              <= '0;
      cpu_resume       <= 1'b0;
      cpu_reset_vector <= 1'b0;
    end else begin
      cpu_resume       <= 1'b0;
      cpu_reset_vector <= 1'b0;
      case (state)
        smpm_pkg::SMPM_RUN: begin
          if (enter) begin
            state    <= smpm_pkg::SMPM_SLEEP;
            cur_mode <= sel_mode;
          end
        end
        smpm_pkg::SMPM_SLEEP: begin
          if (sys_reset_req) begin
            state            <= smpm_pkg::SMPM_RUN;
            cpu_reset_vector <= 1'b1;
          end else if (wake) begin
            state <= smpm_pkg::SMPM_STARTUP;
            cnt   <= startup_len;
          end
        end
        smpm_pkg::SMPM_STARTUP: begin
          if (sys_reset_req) begin
            state            <= smpm_pkg::SMPM_RUN;
            cpu_reset_vector <= 1'b1;
          end else if (cnt <= smpm_pkg::CNT_W'(1)) begin
            state <= smpm_pkg::SMPM_HALT;
            cnt   <= smpm_pkg::CNT_W'(smpm_pkg::WAKE_HALT_CYCLES);
          end else begin
            cnt <= cnt - smpm_pkg::CNT_W'(1);
          end
        end
        smpm_pkg::SMPM_HALT: begin
          if (sys_reset_req) begin
            state            <= smpm_pkg::SMPM_RUN;
            cpu_reset_vector <= 1'b1;
          end else if (cnt <= smpm_pkg::CNT_W'(1)) begin
            state      <= smpm_pkg::SMPM_RUN;
            cpu_resume <= 1'b1;
          end else begin
            cnt <= cnt - smpm_pkg::CNT_W'(1);
          end
        end
        default: state <= smpm_pkg::SMPM_RUN;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Clock, oscillator and helper enables
  // ---------------------------------------------------------------
  wire gated = asleep;
  wire next_core = !gated;
  wire next_io   = !gated || is_idle;
  wire next_asy  = !gated || is_idle || (save_like && t2_async);
  wire next_osc  = !gated || is_idle || stby_like ||
                   (pd_or_ps && debug_enable_fuse && jtag_on);
  wire next_tosc = next_asy && t2_async;
  // A comparator on the internal reference stays on in deep sleep and keeps the reference up.
  wire next_cmp  = !cmp_off_bit && (!is_deep || ac_bg);
  wire next_vref = bod_fuse_en || (next_cmp && ac_bg);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      core_clock_en           <= 1'b1;
      program_memory_clock_en <= 1'b1;
      peripheral_clock_en     <= 1'b1;
      async_timer_clock_en    <= 1'b1;
      main_osc_en             <= 1'b1;
      timer_osc_en            <= 1'b0;
      comparator_en           <= 1'b0;
      vref_en                 <= 1'b0;
      bod_en                  <= 1'b0;
      wdt_run                 <= 1'b0;
      input_buf_en            <= 1'b1;
      wake_buf_en             <= 1'b1;
      jtag_active             <= 1'b0;
      tdo_o                   <= 1'b0;
      tdo_oe                  <= 1'b0;
    end else begin
      core_clock_en           <= next_core;
      program_memory_clock_en <= next_core;
      peripheral_clock_en     <= next_io;
      async_timer_clock_en    <= next_asy;
      main_osc_en             <= next_osc;
      timer_osc_en            <= next_tosc;
      comparator_en           <= next_cmp;
      vref_en                 <= next_vref;
      bod_en                  <= bod_fuse_en;
      wdt_run                 <= wdt_en;
      input_buf_en            <= next_io;
      wake_buf_en             <= 1'b1;
      jtag_active             <= jtag_on;
      tdo_o                   <= tdo_data;
      tdo_oe                  <= jtag_on && tap_shifting;
    end
  end

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ctrl <= 8'h00;
    end else if (reg_wr && reg_addr == smpm_pkg::ADDR_CTRL) begin
      ctrl <= reg_wdata;
    end
  end

  wire [7:0] status_word = {3'h0, cur_mode, state == smpm_pkg::SMPM_HALT, asleep};
  wire [7:0] wake_word   = {1'b0, pin_f[smpm_pkg::PIN_CMP:smpm_pkg::PIN_A], wake};
  wire [7:0] rd_mux = (reg_addr == smpm_pkg::ADDR_CTRL)   ? ctrl :
                      (reg_addr == smpm_pkg::ADDR_STATUS) ? status_word :
                      (reg_addr == smpm_pkg::ADDR_WAKE)   ? wake_word : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence halt_phase;
    (state == smpm_pkg::SMPM_HALT && !sys_reset_req) [*4];
  endsequence

  sleep_entry_a: assert property (enter && state == smpm_pkg::SMPM_RUN |=> asleep)
    else $error("sleep not entered");
  no_bad_entry_a: assert property (state == smpm_pkg::SMPM_RUN && sleep_instr &&
      !mode_valid(sel_mode, crystal_sel) |=> !asleep)
    else $error("reserved mode entered sleep");
  halt_resume_a: assert property ($rose(state == smpm_pkg::SMPM_HALT) ##0 halt_phase
      |=> cpu_resume)
    else $error("resume not after four halt cycles");
  reset_wake_a: assert property (asleep && sys_reset_req |=> cpu_reset_vector)
    else $error("reset did not wake");
  idle_clocks_a: assert property (is_idle |=> !core_clock_en && peripheral_clock_en)
    else $error("idle gating wrong");
  deep_io_a: assert property (is_deep |=> !peripheral_clock_en && !input_buf_en)
    else $error("deep sleep io clock on");
  stby_wake_a: assert property (asleep && stby_like && wake && !sys_reset_req
      |=> ##6 state == smpm_pkg::SMPM_HALT)
    else $error("standby wake not six cycles");
  cmp_off_a: assert property (is_deep && !ac_bg |=> !comparator_en)
    else $error("comparator on in deep sleep");
  tdo_float_a: assert property (!tap_shifting |=> !tdo_oe)
    else $error("tdo driven while idle");
  bod_keep_a: assert property (bod_fuse_en |=> bod_en && vref_en)
    else $error("brown-out off");
  resume_pulse_a: assert property (cpu_resume |=> !cpu_resume)
    else $error("resume pulse too long");
  pulse_excl_a: assert property (!(cpu_resume && cpu_reset_vector))
    else $error("resume and restart together");

  // ---------------------------------------------------------------
  // Checks on the wake paths and the power helpers
  // ---------------------------------------------------------------
  // Power-save with the global enable clear ignores timer events; only pins may wake it.
  sequence idle_wake_s;
    is_idle && irq_pending && !sys_reset_req;
  endsequence

  sequence save_hold_s;
    asleep && save_like && !global_irq_en && !deep_ext && !sys_reset_req;
  endsequence

  idle_wake_a: assert property (idle_wake_s |=> state == smpm_pkg::SMPM_STARTUP)
    else $error("idle did not wake on interrupt");
  save_gate_a: assert property (save_hold_s |=> asleep)
    else $error("timer woke without global enable");
  run_clocks_a: assert property (!asleep |=> core_clock_en && peripheral_clock_en)
    else $error("clock gated while running");
  save_async_a: assert property (asleep && save_like && t2_async
      |=> async_timer_clock_en)
    else $error("async clock stopped in power-save");
  pdown_stop_a: assert property (asleep && cur_mode == smpm_pkg::MODE_PDOWN
      |=> !async_timer_clock_en && !timer_osc_en)
    else $error("power-down left async clock on");
  stby_osc_a: assert property (asleep && stby_like |=> main_osc_en)
    else $error("oscillator off in standby");
  debug_osc_a: assert property (asleep && pd_or_ps && debug_enable_fuse && jtag_on
      |=> main_osc_en)
    else $error("oscillator off with debug enabled");
  idle_buf_a: assert property (is_idle |=> input_buf_en && wake_buf_en)
    else $error("input buffers off in idle");
  wdt_keep_a: assert property (wdt_en |=> wdt_run)
    else $error("watchdog stopped");
  jtag_off_a: assert property (!jtag_on |=> !jtag_active && !tdo_oe)
    else $error("jtag active while disabled");
  vref_off_a: assert property (!bod_fuse_en && cmp_off_bit
      |=> !vref_en && !comparator_en)
    else $error("reference on with no user");
  edge_block_a: assert property (is_deep && !ext_a_level_en && !ext_b_level_en
      && !ext_c_en && !pin_change_en && !t2_wake && !sys_reset_req |=> asleep)
    else $error("edge interrupt woke deep sleep");
  deep_delay_a: assert property (is_deep && !stby_like && wake && !sys_reset_req
      |=> state == smpm_pkg::SMPM_STARTUP && cnt == smpm_pkg::CNT_W'(STARTUP_CYCLES))
    else $error("power-down wake delay wrong");
endmodule : smpm_top
`default_nettype wire

//--- sim/smpm_core_model.sv
// Core-side model: counts the resume and restart pulses that the sleep manager hands the core.
`timescale 1ns/10ps
`default_nettype none
module smpm_core_model (
  input  wire logic clk_sys,          // System clock.
  input  wire logic resetn,           // Synchronous reset, active low.
  input  wire logic cpu_resume,       // Resume pulse from the manager.
  input  wire logic cpu_reset_vector, // Restart pulse from the manager.
  output var  int   n_resume,         // Resumes after the sleep instruction.
  output var  int   n_restart         // Restarts from the reset vector.
);
  // A restart must never be counted as a resume, so the two stay apart.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      n_resume  <= 0;
      n_restart <= 0;
    end else begin
      n_resume  <= n_resume + int'(cpu_resume);
      n_restart <= n_restart + int'(cpu_reset_vector);
    end
  end
endmodule : smpm_core_model
`default_nettype wire

//--- sim/smpm_top_test.sv
// Self-checking bench for the sleep-mode manager.
`timescale 1ns/10ps
`default_nettype none
module smpm_top_test;
  logic clk_sys = 0, resetn = 0, reg_wr = 0, reg_rd = 0, sleep_instr = 0;
  logic [3:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, v;
  logic crystal_sel = 0, debug_enable_fuse = 0, jtag_enable_fuse = 0, bod_fuse_en = 0;
  logic wdt_en = 0, tap_shifting = 0, tdo_data = 0, sys_reset_req = 0, global_irq_en = 0;
  logic irq_pending = 0, ext_irq_a = 0, ext_irq_b = 0, ext_irq_c = 0, ext_a_level_en = 0;
  logic ext_b_level_en = 0, ext_c_en = 0, pin_change = 0, pin_change_en = 0, t2_ovf = 0;
  logic t2_cmp = 0, t2_ovf_ie = 0, t2_cmp_ie = 0;
  logic core_clock_en, program_memory_clock_en, peripheral_clock_en, async_timer_clock_en;
  logic main_osc_en, timer_osc_en, comparator_en, vref_en, bod_en, wdt_run, input_buf_en;
  logic wake_buf_en, jtag_active, tdo_o, tdo_oe, cpu_resume, cpu_reset_vector;
  int   bad_count = 0, n_tests = 0, n_resume, n_restart;

  // Four start-up cycles keep the power-down wake short; expectations use the same value.
  localparam int STARTUP = 4;

  always #4 clk_sys = ~clk_sys;

  smpm_top #(.STARTUP_CYCLES(STARTUP)) dut_u (.clk_sys, .resetn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .sleep_instr, .crystal_sel, .debug_enable_fuse,
    .jtag_enable_fuse, .bod_fuse_en, .wdt_en, .tap_shifting, .tdo_data, .sys_reset_req,
    .global_irq_en, .irq_pending, .ext_irq_a, .ext_irq_b, .ext_irq_c, .ext_a_level_en,
    .ext_b_level_en, .ext_c_en, .pin_change, .pin_change_en, .t2_ovf, .t2_cmp, .t2_ovf_ie,
    .t2_cmp_ie, .core_clock_en, .program_memory_clock_en, .peripheral_clock_en,
    .async_timer_clock_en, .main_osc_en, .timer_osc_en, .comparator_en, .vref_en, .bod_en,
    .wdt_run, .input_buf_en, .wake_buf_en, .jtag_active, .tdo_o, .tdo_oe, .cpu_resume,
    .cpu_reset_vector);

  smpm_core_model core_u (.clk_sys, .resetn, .cpu_resume, .cpu_reset_vector, .n_resume,
    .n_restart);

  function automatic logic [7:0] clks();
    return {2'h0, core_clock_en, program_memory_clock_en, peripheral_clock_en,
            async_timer_clock_en, main_osc_en, timer_osc_en};
  endfunction : clks

  function automatic logic [7:0] pwr();
    return {2'h0, comparator_en, vref_en, bod_en, wdt_run, input_buf_en, wake_buf_en};
  endfunction : pwr

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // Writes the mode with sleep enable set, issues the sleep instruction, checks the status.
  task automatic go(input logic [2:0] m, input logic [7:0] extra, input logic [7:0] st);
    wr(smpm_pkg::ADDR_CTRL, extra | {4'h0, m, 1'b1});
    @(posedge clk_sys);
    sleep_instr <= 1'b1;
    @(posedge clk_sys);
    sleep_instr <= 1'b0;
    tick(3);
    rd(smpm_pkg::ADDR_STATUS, v);
    check(v, st);
  endtask : go

  // Counts edges from the wake event to the resume pulse; pin sources add a filter lag.
  task automatic await_resume(input int n_start);
    int n;
    n = 0;
    while (cpu_resume !== 1'b1 && n < 60) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check(8'((n >= n_start + 4) && (n <= n_start + 11)), 8'h01);
  endtask : await_resume

  task automatic quiet();
    @(posedge clk_sys);
    {irq_pending, ext_irq_a, ext_irq_c, pin_change, t2_ovf, t2_cmp} <= 6'h00;
    global_irq_en <= 1'b0;
    tick(12);
  endtask : quiet

  task automatic wake_c(input int n_start);
    @(posedge clk_sys);
    ext_c_en  <= 1'b1;
    ext_irq_c <= 1'b1;
    await_resume(n_start);
    quiet();
  endtask : wake_c

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    tick(1);
    check(clks(), 8'h3E);
    check(pwr(), 8'h23);
    check({jtag_active, tdo_oe}, 8'h00);
    rd(smpm_pkg::ADDR_CTRL, v);
    check(v, 8'h00);
    rd(4'hC, v);
    check(v, 8'h00);
    wr(smpm_pkg::ADDR_CTRL, 8'hAA);
    rd(smpm_pkg::ADDR_CTRL, v);
    check(v, 8'hAA);
    @(posedge clk_sys);
    {bod_fuse_en, wdt_en} <= 2'h3;
    // Sleep enable clear, reserved codes, and standby without a crystal all keep running.
    wr(smpm_pkg::ADDR_CTRL, 8'h00);
    @(posedge clk_sys);
    sleep_instr <= 1'b1;
    @(posedge clk_sys);
    sleep_instr <= 1'b0;
    tick(3);
    check(clks(), 8'h3E);
    go(smpm_pkg::MODE_RES1, 8'h00, 8'h00);
    go(smpm_pkg::MODE_RES4, 8'h00, 8'h00);
    go(smpm_pkg::MODE_RES5, 8'h00, 8'h00);
    go(smpm_pkg::MODE_STBY, 8'h00, 8'h00);
    check(clks(), 8'h3E);
    go(smpm_pkg::MODE_IDLE, 8'h80, 8'h01);
    check(clks(), 8'h0F);
    check(pwr(), 8'h3F);
    @(posedge clk_sys);
    irq_pending <= 1'b1;
    await_resume(1);
    quiet();
    check(clks(), 8'h3F);
    go(smpm_pkg::MODE_PDOWN, 8'h00, 8'h09);
    check(clks(), 8'h00);
    check(pwr(), 8'h1D);
    @(posedge clk_sys);
    {irq_pending, ext_irq_a} <= 2'h3;
    tick(20);
    rd(smpm_pkg::ADDR_STATUS, v);
    check(v, 8'h09);
    quiet();
    wake_c(STARTUP);
    go(smpm_pkg::MODE_PSAVE, 8'h80, 8'h0D);
    check(clks(), 8'h05);
    @(posedge clk_sys);
    {t2_ovf_ie, t2_ovf} <= 2'h3;
    tick(20);
    rd(smpm_pkg::ADDR_STATUS, v);
    check(v, 8'h0D);
    @(posedge clk_sys);
    global_irq_en <= 1'b1;
    await_resume(STARTUP);
    quiet();
    @(posedge clk_sys);
    crystal_sel <= 1'b1;
    go(smpm_pkg::MODE_STBY, 8'h00, 8'h19);
    check(clks(), 8'h02);
    @(posedge clk_sys);
    {pin_change_en, pin_change} <= 2'h3;
    await_resume(smpm_pkg::STBY_WAKE_CYCLES);
    quiet();
    go(smpm_pkg::MODE_XSTBY, 8'h80, 8'h1D);
    check(clks(), 8'h07);
    @(posedge clk_sys);
    {t2_cmp_ie, t2_cmp, global_irq_en} <= 3'h7;
    await_resume(smpm_pkg::STBY_WAKE_CYCLES);
    quiet();
    go(smpm_pkg::MODE_PDOWN, 8'h00, 8'h09);
    @(posedge clk_sys);
    sys_reset_req <= 1'b1;
    for (int n = 0; n < 20 && cpu_reset_vector !== 1'b1; n++) tick(1);
    check(cpu_reset_vector, 8'h01);
    @(posedge clk_sys);
    sys_reset_req <= 1'b0;
    tick(4);
    check(8'(n_resume), 8'h05);
    check(8'(n_restart), 8'h01);
    go(smpm_pkg::MODE_PDOWN, 8'h40, 8'h09);
    check(comparator_en, 8'h01);
    wake_c(STARTUP);
    @(posedge clk_sys);
    {debug_enable_fuse, jtag_enable_fuse} <= 2'h3;
    go(smpm_pkg::MODE_PDOWN, 8'h00, 8'h09);
    check(main_osc_en, 8'h01);
    check({jtag_active, tdo_oe}, 8'h02);
    wake_c(STARTUP);
    @(posedge clk_sys);
    {tap_shifting, tdo_data} <= 2'h3;
    tick(3);
    check({tdo_oe, tdo_o}, 8'h03);
    wr(smpm_pkg::ADDR_CTRL, 8'h10);
    tick(2);
    check(jtag_active, 8'h00);
    @(posedge clk_sys);
    {bod_fuse_en, jtag_enable_fuse} <= 2'h0;
    wr(smpm_pkg::ADDR_CTRL, 8'h00);
    tick(2);
    check(jtag_active, 8'h00);
    wr(smpm_pkg::ADDR_CTRL, 8'h20);
    tick(2);
    check({comparator_en, vref_en}, 8'h00);
    wr(smpm_pkg::ADDR_CTRL, 8'h40);
    tick(2);
    check(vref_en, 8'h01);
    print_verdict();
  end
endmodule : smpm_top_test
`default_nettype wire
